// ==== inc/dps_pkg.sv ====
// Constants, register map and state codes of the drive protection supervisor
package dps_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int VB_W = 10;
	localparam int CUR_W = 8;
	localparam int TMR_W = 10;
	// Register offsets (byte addresses, one word each)
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_ENERGY = 8'h04;
	localparam logic [7:0] OFS_BRAKE = 8'h08;
	localparam logic [7:0] OFS_PLOSS = 8'h0C;
	localparam logic [7:0] OFS_FRST = 8'h10;
	localparam logic [7:0] OFS_OVLD = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;
	localparam logic [7:0] OFS_CMD = 8'h1C;
	// Field positions
	localparam int F_VREG = 0;
	localparam int F_PLR = 2;
	localparam int F_OLMODE = 4;
	localparam int F_START = 8;
	localparam int F_ESAVE = 0;
	localparam int F_BTHR = 0;
	localparam int F_BDUTY = 16;
	localparam int F_PLT = 0;
	localparam int F_FLIM = 8;
	localparam int F_FTO = 16;
	localparam int F_RCNT = 0;
	localparam int F_RDLY = 8;
	localparam int F_OLVL = 0;
	localparam int F_OTIME = 8;
	localparam int F_FCLR = 0;
	// Reset values
	localparam logic [1:0] RST_VREG = 2'h1;
	localparam logic [6:0] RST_ESAVE = 7'h00;
	localparam logic [9:0] RST_BTHR_HI = 10'h2BC;
	localparam logic [9:0] RST_BTHR_LO = 10'h172;
	localparam logic [6:0] RST_BDUTY = 7'h32;
	localparam logic RST_PLR = 1'b0;
	localparam logic [6:0] RST_PLT = 7'h32;
	localparam logic [7:0] RST_FLIM = 8'h96;
	localparam logic [6:0] RST_FTO = 7'h05;
	localparam logic [2:0] RST_RCNT = 3'h0;
	localparam logic [6:0] RST_RDLY = 7'h02;
	localparam logic [1:0] RST_OLMODE = 2'h0;
	localparam logic [7:0] RST_OLVL = 8'h00;
	localparam logic [6:0] RST_OTIME = 7'h02;
	localparam logic [3:0] RST_START = 4'h0;
	// Setting limits
	localparam int MAX_VREG = 2;
	localparam int MAX_ESAVE = 100;
	localparam int MIN_BDUTY = 40;
	localparam int MAX_PCT = 100;
	localparam int MAX_PLT = 100;
	localparam int MAX_CUR = 200;
	localparam int MAX_FTO = 10;
	localparam int MAX_RCNT = 5;
	localparam int MAX_RDLY = 100;
	localparam int MAX_OTIME = 20;
	// Timing
	localparam int CLK_PERIOD_NS = 4;
	localparam int TICK_PERIOD_NS = 100_000_000;
	localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int TENTHS_PER_S = 10;
	localparam int CLEAN_RUN_S = 60;
	localparam int BRAKE_HYST_V = 20;
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_RUN = 6'h02,
		ST_OUTAGE = 6'h04,
		ST_FLYING = 6'h08,
		ST_WAIT = 6'h10,
		ST_LOCK = 6'h20
	} dps_state_t;
endpackage

// ==== src/dps_supervisor.sv ====
// Drive protection and restart supervisor: settings, brake, restarts, overload
//
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/1ns
module dps_supervisor
#(
	parameter int TICK_CYCLES = dps_pkg::TICK_CYCLES,
	parameter bit HIGH_VOLT_CLASS = 1'b1,
	parameter int BRAKE_HYST_V = dps_pkg::BRAKE_HYST_V
)
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [dps_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [dps_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [dps_pkg::DATA_W-1:0] reg_rdata,
	input wire logic supply_ok,
	input wire logic run_request,
	input wire logic decelerating,
	input wire logic at_constant_speed,
	input wire logic fault_alarm,
	input wire logic brake_unit_internal,
	input wire logic speed_tracked,
	input wire logic [dps_pkg::VB_W-1:0] dc_bus_volts,
	input wire logic [dps_pkg::CUR_W-1:0] out_current_pct,
	output logic avr_enable,
	output logic [6:0] energy_save_out,
	output logic brake_gate,
	output logic run_enable,
	output logic flying_sweep,
	output logic sweep_hold,
	output logic restart_start,
	output logic [3:0] start_method_select,
	output logic output_stop,
	output logic protection_trip,
	output logic overload_prealarm,
	output logic overload_alarm
);
	import dps_pkg::*;

	localparam int SW = 2 * CUR_W + VB_W - CUR_W + 7;
	localparam int TW = $clog2(TICK_CYCLES + 1);
	localparam logic [9:0] BTHR_RST = HIGH_VOLT_CLASS ? RST_BTHR_HI
		: RST_BTHR_LO;

	function automatic logic [15:0] clamp(input logic [15:0] v,
		input int lo, input int hi);
		logic [15:0] r;
		r = v;
		if (v < 16'(lo))
			r = 16'(lo);
		else if (v > 16'(hi))
			r = 16'(hi);
		return r;
	endfunction

	function automatic logic [TMR_W-1:0] sec_to_ticks(input logic [6:0] s);
		return TMR_W'(int'(s) * TENTHS_PER_S);
	endfunction

	// Pin synchronisers: the first stage feeds the second only
	logic [SW-1:0] pin_bus, sync1_ff, sync2_ff;
	logic supply_s, run_s, decel_s, const_s, alarm_s, internal_s, tracked_s;
	logic [VB_W-1:0] vbus_s;
	logic [CUR_W-1:0] cur_s;
	assign pin_bus = {supply_ok, run_request, decelerating, at_constant_speed,
		fault_alarm, brake_unit_internal, speed_tracked, dc_bus_volts,
		out_current_pct};
	assign {supply_s, run_s, decel_s, const_s, alarm_s, internal_s, tracked_s,
		vbus_s, cur_s} = sync2_ff;
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sync1_ff <= '0;
			sync2_ff <= '0;
		end
		else
		begin
			sync1_ff <= pin_bus;
			sync2_ff <= sync1_ff;
		end
	end

	// Settings registers
	logic [1:0] vreg_ff, nxt_vreg, olmode_ff, nxt_olmode;
	logic plr_ff, nxt_plr;
	logic [3:0] start_ff, nxt_start;
	logic [6:0] esave_ff, nxt_esave, bduty_ff, nxt_bduty, plt_ff, nxt_plt;
	logic [6:0] fto_ff, nxt_fto, rdly_ff, nxt_rdly, otime_ff, nxt_otime;
	logic [9:0] bthr_ff, nxt_bthr;
	logic [7:0] flim_ff, nxt_flim, olvl_ff, nxt_olvl;
	logic [2:0] rcnt_ff, nxt_rcnt;
	logic [DATA_W-1:0] rdata_ff, nxt_rdata, status_w;
	logic fault_clr;
	dps_state_t state_ff, nxt_state;
	logic [2:0] fcnt_ff, nxt_fcnt;
	logic chop_ff, hold_ff, trip_ff, pre_ff, olal_ff;

	assign fault_clr = reg_wr && reg_addr == OFS_CMD && reg_wdata[F_FCLR];
	assign status_w = {17'h00000, avr_enable, hold_ff, trip_ff, olal_ff,
		pre_ff, chop_ff, fcnt_ff, state_ff};

	always_comb
	begin
		{nxt_vreg, nxt_plr, nxt_olmode, nxt_start} =
			{vreg_ff, plr_ff, olmode_ff, start_ff};
		{nxt_esave, nxt_bthr, nxt_bduty, nxt_plt, nxt_flim, nxt_fto} =
			{esave_ff, bthr_ff, bduty_ff, plt_ff, flim_ff, fto_ff};
		{nxt_rcnt, nxt_rdly, nxt_olvl, nxt_otime} =
			{rcnt_ff, rdly_ff, olvl_ff, otime_ff};
		if (reg_wr)
		begin
			unique case (reg_addr)
				OFS_CTRL:
				begin
					nxt_vreg = 2'(clamp(16'(reg_wdata[F_VREG+:2]), 0,
						MAX_VREG));
					nxt_plr = reg_wdata[F_PLR];
					nxt_olmode = reg_wdata[F_OLMODE+:2];
					nxt_start = reg_wdata[F_START+:4];
				end
				OFS_ENERGY:
					nxt_esave = 7'(clamp(16'(reg_wdata[F_ESAVE+:7]), 0,
						MAX_ESAVE));
				OFS_BRAKE:
				begin
					nxt_bthr = reg_wdata[F_BTHR+:10];
					nxt_bduty = 7'(clamp(16'(reg_wdata[F_BDUTY+:7]),
						MIN_BDUTY, MAX_PCT));
				end
				OFS_PLOSS:
				begin
					nxt_plt = 7'(clamp(16'(reg_wdata[F_PLT+:7]), 0,
						MAX_PLT));
					nxt_flim = 8'(clamp(16'(reg_wdata[F_FLIM+:8]), 0,
						MAX_CUR));
					nxt_fto = 7'(clamp(16'(reg_wdata[F_FTO+:7]), 0,
						MAX_FTO));
				end
				OFS_FRST:
				begin
					nxt_rcnt = 3'(clamp(16'(reg_wdata[F_RCNT+:3]), 0,
						MAX_RCNT));
					nxt_rdly = 7'(clamp(16'(reg_wdata[F_RDLY+:7]), 0,
						MAX_RDLY));
				end
				OFS_OVLD:
				begin
					nxt_olvl = 8'(clamp(16'(reg_wdata[F_OLVL+:8]), 0,
						MAX_CUR));
					nxt_otime = 7'(clamp(16'(reg_wdata[F_OTIME+:7]), 0,
						MAX_OTIME));
				end
				default:
				begin
				end
			endcase
		end
		nxt_rdata = '0;
		if (reg_rd)
		begin
			unique case (reg_addr)
				OFS_CTRL: nxt_rdata = DATA_W'({start_ff, 2'h0, olmode_ff,
					1'b0, plr_ff, vreg_ff});
				OFS_ENERGY: nxt_rdata = DATA_W'(esave_ff);
				OFS_BRAKE: nxt_rdata = DATA_W'({bduty_ff, 6'h00, bthr_ff});
				OFS_PLOSS: nxt_rdata = DATA_W'({fto_ff, flim_ff, 1'b0,
					plt_ff});
				OFS_FRST: nxt_rdata = DATA_W'({rdly_ff, 5'h00, rcnt_ff});
				OFS_OVLD: nxt_rdata = DATA_W'({otime_ff, olvl_ff});
				OFS_STATUS: nxt_rdata = status_w;
				default: nxt_rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			{vreg_ff, plr_ff, olmode_ff, start_ff} <=
				{RST_VREG, RST_PLR, RST_OLMODE, RST_START};
			{esave_ff, bthr_ff, bduty_ff} <= {RST_ESAVE, BTHR_RST, RST_BDUTY};
			{plt_ff, flim_ff, fto_ff} <= {RST_PLT, RST_FLIM, RST_FTO};
			{rcnt_ff, rdly_ff, olvl_ff, otime_ff} <=
				{RST_RCNT, RST_RDLY, RST_OLVL, RST_OTIME};
			rdata_ff <= '0;
		end
		else
		begin
			{vreg_ff, plr_ff, olmode_ff, start_ff} <=
				{nxt_vreg, nxt_plr, nxt_olmode, nxt_start};
			{esave_ff, bthr_ff, bduty_ff} <= {nxt_esave, nxt_bthr, nxt_bduty};
			{plt_ff, flim_ff, fto_ff} <= {nxt_plt, nxt_flim, nxt_fto};
			{rcnt_ff, rdly_ff, olvl_ff, otime_ff} <=
				{nxt_rcnt, nxt_rdly, nxt_olvl, nxt_otime};
			rdata_ff <= nxt_rdata;
		end
	end
	assign reg_rdata = rdata_ff;
	assign start_method_select = start_ff;

	// Common 0.1 s timebase
	logic [TW-1:0] tick_cnt_ff, nxt_tick_cnt;
	logic tick;
	assign tick = tick_cnt_ff == TW'(TICK_CYCLES - 1);
	always_comb
		nxt_tick_cnt = tick ? '0 : tick_cnt_ff + 1'b1;
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			tick_cnt_ff <= '0;
		else
			tick_cnt_ff <= nxt_tick_cnt;
	end

	// Regulation, energy saving and brake chopper
	logic [6:0] pwm_ff, nxt_pwm, esave_out_ff, nxt_esave_out;
	logic nxt_chop, gate_ff, nxt_gate, avr_ff, nxt_avr;
	logic [9:0] release_v;
	assign release_v = bthr_ff > 10'(BRAKE_HYST_V) ?
		bthr_ff - 10'(BRAKE_HYST_V) : 10'h000;
	always_comb
	begin
		nxt_avr = vreg_ff == 2'h1 || (vreg_ff == 2'h2 && !decel_s);
		nxt_esave_out = const_s ? esave_ff : 7'h00;
		nxt_chop = chop_ff;
		if (!internal_s)
			nxt_chop = 1'b0;
		else if (vbus_s > bthr_ff)
			nxt_chop = 1'b1;
		else if (vbus_s < release_v)
			nxt_chop = 1'b0;
		nxt_pwm = pwm_ff == 7'(MAX_PCT - 1) ? 7'h00 : pwm_ff + 7'h01;
		nxt_gate = nxt_chop && pwm_ff < bduty_ff;
	end
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			{avr_ff, chop_ff, gate_ff} <= 3'h0;
			{esave_out_ff, pwm_ff} <= 14'h0000;
		end
		else
		begin
			{avr_ff, chop_ff, gate_ff} <= {nxt_avr, nxt_chop, nxt_gate};
			{esave_out_ff, pwm_ff} <= {nxt_esave_out, nxt_pwm};
		end
	end
	assign avr_enable = avr_ff;
	assign energy_save_out = esave_out_ff;
	assign brake_gate = gate_ff;

	// Overload timing
	logic [TMR_W-1:0] oltmr_ff, nxt_oltmr;
	logic over, nxt_pre, nxt_olal, ol_stop_evt;
	always_comb
	begin
		over = olvl_ff != 8'h00 && (olmode_ff[1] || const_s)
			&& state_ff == ST_RUN && cur_s > olvl_ff;
		nxt_oltmr = '0;
		if (over)
			nxt_oltmr = (tick && oltmr_ff != '1) ? oltmr_ff + 1'b1 : oltmr_ff;
		nxt_pre = over && {oltmr_ff, 1'b0} >=
			{1'b0, sec_to_ticks(otime_ff)};
		nxt_olal = over && oltmr_ff > sec_to_ticks(otime_ff);
		ol_stop_evt = nxt_olal && !olal_ff && olmode_ff[0];
	end
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			oltmr_ff <= '0;
			{pre_ff, olal_ff} <= 2'h0;
		end
		else
		begin
			oltmr_ff <= nxt_oltmr;
			{pre_ff, olal_ff} <= {nxt_pre, nxt_olal};
		end
	end
	assign overload_prealarm = pre_ff;
	assign overload_alarm = olal_ff;

	// Run, outage, flying restart and fault restart sequencing
	logic [TMR_W-1:0] tmr_ff, nxt_tmr, clean_ff, nxt_clean;
	logic restarted_ff, nxt_restarted, alarm_d_ff, nxt_trip, nxt_hold;
	logic start_ff_p, nxt_start_p, alarm, alarm_rise;
	assign alarm_rise = alarm_s && !alarm_d_ff;
	always_comb
	begin
		nxt_state = state_ff;
		nxt_tmr = (tick && tmr_ff != '1) ? tmr_ff + 1'b1 : tmr_ff;
		{nxt_fcnt, nxt_clean, nxt_restarted} = {fcnt_ff, clean_ff,
			restarted_ff};
		nxt_trip = trip_ff;
		nxt_start_p = 1'b0;
		alarm = 1'b0;
		unique case (state_ff)
			ST_IDLE:
			begin
				nxt_tmr = '0;
				if (supply_s && run_s)
					nxt_state = ST_RUN;
			end
			ST_RUN, ST_FLYING:
			begin
				if (!supply_s)
				begin
					nxt_tmr = '0;
					// Only a retained command goes through the outage and flying restart path
					nxt_state = plr_ff ? ST_OUTAGE : ST_IDLE;
				end
				else if (!run_s)
					nxt_state = ST_IDLE;
				else if (alarm_rise || ol_stop_evt)
					alarm = 1'b1;
				else if (state_ff == ST_FLYING && tracked_s)
					nxt_state = ST_RUN;
				else if (state_ff == ST_FLYING &&
					tmr_ff >= sec_to_ticks(fto_ff))
				begin
					nxt_trip = 1'b1;
					alarm = 1'b1;
				end
				if (state_ff == ST_RUN && restarted_ff && tick)
				begin
					nxt_clean = clean_ff + 1'b1;
					if (clean_ff == TMR_W'(CLEAN_RUN_S * TENTHS_PER_S - 1))
					begin
						nxt_fcnt = 3'h0;
						nxt_restarted = 1'b0;
					end
				end
			end
			ST_OUTAGE:
			begin
				if (tmr_ff > TMR_W'(plt_ff))
					nxt_state = ST_IDLE;
				else if (supply_s)
				begin
					nxt_tmr = '0;
					nxt_state = ST_FLYING;
				end
			end
			ST_WAIT:
			begin
				if (!supply_s)
					nxt_state = ST_IDLE;
				else if (tmr_ff >= sec_to_ticks(rdly_ff))
				begin
					nxt_start_p = 1'b1;
					nxt_restarted = 1'b1;
					nxt_clean = '0;
					nxt_trip = 1'b0;
					nxt_state = ST_RUN;
				end
			end
			ST_LOCK:
			begin
				if (fault_clr)
				begin
					nxt_fcnt = 3'h0;
					nxt_trip = 1'b0;
					nxt_restarted = 1'b0;
					nxt_state = ST_IDLE;
				end
			end
		endcase
		if (alarm)
		begin
			nxt_tmr = '0;
			nxt_clean = '0;
			// Alarm outranks a clean-run clear in the same cycle
			nxt_fcnt = fcnt_ff;
			if (rcnt_ff == 3'h0 || fcnt_ff >= rcnt_ff)
				nxt_state = ST_LOCK;
			else
			begin
				nxt_fcnt = fcnt_ff + 3'h1;
				nxt_state = ST_WAIT;
			end
		end
		nxt_hold = nxt_state == ST_FLYING && cur_s > flim_ff;
	end
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_ff <= ST_IDLE;
			{tmr_ff, clean_ff} <= '0;
			fcnt_ff <= 3'h0;
			{restarted_ff, alarm_d_ff, trip_ff, start_ff_p, hold_ff} <= 5'h00;
		end
		else
		begin
			state_ff <= nxt_state;
			{tmr_ff, clean_ff} <= {nxt_tmr, nxt_clean};
			fcnt_ff <= nxt_fcnt;
			{restarted_ff, alarm_d_ff, trip_ff, start_ff_p, hold_ff} <=
				{nxt_restarted, alarm_s, nxt_trip, nxt_start_p, nxt_hold};
		end
	end
	assign run_enable = state_ff[1] || state_ff[3];
	assign flying_sweep = state_ff[3];
	assign sweep_hold = hold_ff;
	assign restart_start = start_ff_p;
	assign output_stop = state_ff[5];
	assign protection_trip = trip_ff;
endmodule

// ==== bench/dps_supervisor_monitor.sv ====
// Port assertions for the drive protection supervisor
`timescale 1ns/1ns
module dps_supervisor_monitor
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [dps_pkg::ADDR_W-1:0] reg_addr,
	input wire logic reg_wr,
	input wire logic supply_ok,
	input wire logic at_constant_speed,
	input wire logic brake_unit_internal,
	input wire logic [6:0] energy_save_out,
	input wire logic brake_gate,
	input wire logic run_enable,
	input wire logic flying_sweep,
	input wire logic sweep_hold,
	input wire logic restart_start,
	input wire logic output_stop,
	input wire logic protection_trip,
	input wire logic overload_prealarm,
	input wire logic overload_alarm
);
	import dps_pkg::*;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	// Pins pass two sync flops and one register
	sequence s_pulse;
		restart_start ##1 !restart_start;
	endsequence
	property p_energy;
		energy_save_out != 7'h00 |-> $past(at_constant_speed, 3);
	endproperty
	property p_brake;
		brake_gate |-> $past(brake_unit_internal, 3);
	endproperty
	property p_run;
		run_enable |-> $past(supply_ok, 3);
	endproperty
	property p_hold;
		sweep_hold |-> flying_sweep;
	endproperty
	property p_trip;
		$rose(protection_trip) |-> $past(flying_sweep);
	endproperty
	property p_restart;
		restart_start |-> run_enable ##0 s_pulse;
	endproperty
	property p_lock;
		output_stop && !(reg_wr && reg_addr == OFS_CMD)
			|=> output_stop && !run_enable;
	endproperty
	property p_ovld;
		$rose(overload_alarm) |-> $past(overload_prealarm);
	endproperty
	a_energy: assert property (p_energy)
		else $error("energy saving outside constant speed");
	a_brake: assert property (p_brake)
		else $error("chopper gate without internal brake unit");
	a_run: assert property (p_run)
		else $error("running without supply");
	a_hold: assert property (p_hold)
		else $error("sweep hold outside flying restart");
	a_trip: assert property (p_trip)
		else $error("trip raised outside flying restart");
	a_restart: assert property (p_restart)
		else $error("restart pulse malformed");
	a_lock: assert property (p_lock)
		else $error("lockout left without clear");
	a_ovld: assert property (p_ovld)
		else $error("overload alarm without prealarm");
endmodule
bind dps_supervisor dps_supervisor_monitor u_mon (.clk, .arst_n,
	.reg_addr, .reg_wr, .supply_ok, .at_constant_speed,
	.brake_unit_internal, .energy_save_out, .brake_gate, .run_enable,
	.flying_sweep, .sweep_hold, .restart_start, .output_stop,
	.protection_trip, .overload_prealarm, .overload_alarm);

// ==== bench/dps_supervisor_tb.sv ====
// Self-checking bench for the drive protection supervisor
`timescale 1ns/1ns
module dps_supervisor_tb;
	import dps_pkg::*;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0, reg_rd = 1'b0, fault_alarm = 1'b0;
	logic supply_ok = 1'b0, run_request = 1'b0, decelerating = 1'b0;
	logic at_constant_speed = 1'b0, speed_tracked = 1'b0;
	logic brake_unit_internal = 1'b0;
	logic [9:0] dc_bus_volts = 10'h000;
	logic [7:0] out_current_pct = 8'h00;
	logic [31:0] reg_rdata, v, n;
	logic [6:0] energy_save_out;
	logic [3:0] start_method_select;
	logic avr_enable, brake_gate, run_enable, flying_sweep, sweep_hold;
	logic restart_start, output_stop, protection_trip;
	logic overload_prealarm, overload_alarm;
	int fail_count = 0, checks_done = 0, cyc = 0, restarts = 0;
	logic [31:0] rst_tab [8] = '{32'h1, 32'h0, 32'h003202BC,
		32'h00059632, 32'h200, 32'h200, 32'h4001, 32'h0};
	// Bits: regulation select, decelerating, expected enable
	logic [3:0] vr_tab [4] = '{4'h0, 4'h7, 4'hA, 4'h9};
	logic [9:0] bus_tab [4] = '{10'h2BD, 10'h2B2, 10'h2A7, 10'h2BD};

	// Short tick keeps the sixty second window near 2400 clocks
	dps_supervisor #(.TICK_CYCLES(4)) uut (.clk, .arst_n, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .supply_ok, .run_request,
		.decelerating, .at_constant_speed, .fault_alarm, .brake_unit_internal,
		.speed_tracked, .dc_bus_volts, .out_current_pct, .avr_enable,
		.energy_save_out, .brake_gate, .run_enable, .flying_sweep,
		.sweep_hold, .restart_start, .start_method_select, .output_stop,
		.protection_trip, .overload_prealarm, .overload_alarm);

	always #2 clk = ~clk;

	task results;
		if (fail_count == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Counted off the edge so one-cycle pulses are read settled
	always @(negedge clk)
	begin
		cyc++;
		restarts += int'(restart_start === 1'b1);
		if (cyc == 20000)
		begin
			fail_count++;
			results();
		end
	end

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e)
		begin
			fail_count++;
			$display("ERROR t=%0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic wait_clk(input int k);
		repeat (k) @(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
		// Return on an edge so callers drive inputs there
		@(posedge clk);
	endtask
	// Bounded poll of the status word
	task automatic st(input logic [31:0] m, e, input int lim);
		for (int i = 0; i < lim; i++)
		begin
			rd(OFS_STATUS);
			if ((v & m) === e)
				break;
		end
		chk(v & m, e);
	endtask
	task automatic gate(input logic [31:0] e);
		wait_clk(8);
		n = 0;
		repeat (100)
		begin
			@(negedge clk);
			n += 32'(brake_gate);
		end
		@(posedge clk);
		chk(n, e);
	endtask
	task automatic alarm;
		fault_alarm <= 1'b1;
		wait_clk(4);
		fault_alarm <= 1'b0;
	endtask

	initial
	begin
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		wait_clk(4);
		for (int i = 0; i < 8; i++)
		begin
			rd(i == 7 ? 8'h20 : 8'(i * 4));
			chk(v, rst_tab[i]);
		end
		for (int i = 0; i < 4; i++)
		begin
			decelerating <= vr_tab[i][1];
			wr(OFS_CTRL, {30'h0, vr_tab[i][3:2]});
			wait_clk(6);
			chk(avr_enable, vr_tab[i][0]);
		end
		wr(OFS_CTRL, 32'hA03);
		rd(OFS_CTRL);
		chk(v, 32'hA02);
		chk(start_method_select, 32'hA);
		wr(OFS_ENERGY, 32'h64);
		wait_clk(6);
		chk(energy_save_out, 32'h0);
		at_constant_speed <= 1'b1;
		wait_clk(6);
		chk(energy_save_out, 32'h64);
		wr(OFS_BRAKE, 32'h002802BC);
		for (int i = 0; i < 4; i++)
		begin
			brake_unit_internal <= i < 3;
			dc_bus_volts <= bus_tab[i];
			gate(i < 2 ? 32'h28 : 32'h0);
		end
		brake_unit_internal <= 1'b1;
		wr(OFS_BRAKE, 32'h006402BC);
		gate(32'h64);
		wr(OFS_BRAKE, 32'h001E02BC);
		rd(OFS_BRAKE);
		chk(v, 32'h002802BC);
		dc_bus_volts <= 10'h000;
		supply_ok <= 1'b1;
		run_request <= 1'b1;
		st(32'h3F, 32'h2, 10);
		supply_ok <= 1'b0;
		st(32'h3F, 32'h1, 4);
		run_request <= 1'b0;
		supply_ok <= 1'b1;
		wr(OFS_CTRL, 32'h5);
		wr(OFS_PLOSS, 32'h00026402);
		run_request <= 1'b1;
		st(32'h3F, 32'h2, 10);
		supply_ok <= 1'b0;
		wait_clk(2);
		supply_ok <= 1'b1;
		st(32'h3F, 32'h8, 10);
		chk(flying_sweep, 32'h1);
		out_current_pct <= 8'h96;
		st(32'h2000, 32'h2000, 10);
		chk(sweep_hold, 32'h1);
		out_current_pct <= 8'h32;
		st(32'h2000, 32'h0, 10);
		speed_tracked <= 1'b1;
		st(32'h3F, 32'h2, 10);
		speed_tracked <= 1'b0;
		supply_ok <= 1'b0;
		wait_clk(40);
		st(32'h3F, 32'h1, 2);
		run_request <= 1'b0;
		supply_ok <= 1'b1;
		wait_clk(8);
		run_request <= 1'b1;
		st(32'h3F, 32'h2, 10);
		supply_ok <= 1'b0;
		wait_clk(2);
		supply_ok <= 1'b1;
		st(32'h1000, 32'h1000, 100);
		chk(protection_trip, 32'h1);
		st(32'h3F, 32'h20, 4);
		chk(output_stop, 32'h1);
		run_request <= 1'b0;
		wr(OFS_CMD, 32'h1);
		st(32'h103F, 32'h1, 4);
		wr(OFS_CTRL, 32'h1);
		wr(OFS_FRST, 32'h0102);
		run_request <= 1'b1;
		st(32'h3F, 32'h2, 10);
		for (int i = 1; i < 3; i++)
		begin
			alarm();
			st(32'h1FF, 32'h10 | 32'(i << 6), 10);
			wait_clk(20);
			chk(restarts, i - 1);
			st(32'h3F, 32'h2, 40);
			chk(restarts, i);
		end
		alarm();
		st(32'h1FF, 32'hA0, 10);
		run_request <= 1'b0;
		wr(OFS_CMD, 32'h1);
		run_request <= 1'b1;
		st(32'h1FF, 32'h2, 10);
		alarm();
		st(32'h1FF, 32'h42, 60);
		wait_clk(2000);
		rd(OFS_STATUS);
		chk(v & 32'h1C0, 32'h40);
		st(32'h1C0, 32'h0, 400);
		wr(OFS_CTRL, 32'h21);
		wr(OFS_OVLD, 32'h0164);
		out_current_pct <= 8'h96;
		st(32'h400, 32'h400, 40);
		chk(overload_alarm, 32'h0);
		st(32'h800, 32'h800, 40);
		chk(run_enable, 32'h1);
		out_current_pct <= 8'h32;
		st(32'hC00, 32'h0, 20);
		wr(OFS_CTRL, 32'h1);
		at_constant_speed <= 1'b0;
		out_current_pct <= 8'h96;
		wait_clk(80);
		chk(overload_prealarm, 32'h0);
		wr(OFS_CTRL, 32'h21);
		wr(OFS_OVLD, 32'h0100);
		wait_clk(80);
		chk(overload_prealarm, 32'h0);
		wr(OFS_CTRL, 32'h31);
		wr(OFS_OVLD, 32'h0164);
		st(32'h3F, 32'h10, 60);
		results();
	end
endmodule
